// File: core/dbg_params.svh
// Constants for the debug link and breakpoint unit
`ifndef DBG_PARAMS_SVH
`define DBG_PARAMS_SVH

// Register word addresses
`define ADDR_CTRL    3'h0
`define ADDR_STAT    3'h1
`define ADDR_CNT     3'h2
`define ADDR_TXDATA  3'h3
`define ADDR_RXDATA  3'h4
`define ADDR_BAUD    3'h5

// Status bit positions
`define ST_DBG       0
`define ST_LOOP      1
`define ST_BAUD_OK   2
`define ST_TX_BUSY   3
`define ST_RX_FULL   4
`define ST_FRAME     5
`define ST_COLL      6
`define ST_BREAK     7

// Timing and counts
`define BREAK_CYCLES 13'h1000
`define BAUD_OVF     13'h1000
`define BREAK_BITS   6'h0a
`define DATA_BITS    3'h7
`define CNT_MAX      16'hffff
`define CNT_ZERO     16'h0000
`define CNT_ONE      16'h0001

`endif

// File: core/dbg_pkg.sv
// Types shared by the debug link and breakpoint unit
package dbg_pkg;

  typedef enum logic [1:0] {
    CNT_CYCLE, CNT_DOWN, CNT_MATCH, CNT_OFF
  } cnt_mode_e;

  // Control register, bit 0 is the debug mode flag
  typedef struct packed {
    cnt_mode_e cnt_mode;
    logic      flow_ctrl;
    logic      drive_high_assist;
    logic      drive_both;
    logic      break_loop_enable;
    logic      brk_enable;
    logic      debug_mode_flag;
  } ctl_s;

  // Processor view of the breakpoint logic
  typedef struct packed {
    logic        brk_decode;
    logic        fetch_valid;
    logic [15:0] pc;
  } cpu_s;

  typedef enum {
    TX_IDLE, TX_WAIT, TX_HOST_START, TX_START, TX_DATA, TX_STOP
  } tx_state_e;

  typedef enum {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } rx_state_e;

endpackage : dbg_pkg

// File: core/serial_tx.sv
// Character transmitter with pin drive options
`timescale 1ns/1ps
`default_nettype none
`include "dbg_params.svh"
module serial_tx
  import dbg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic [9:0] bit_period,
  input  wire logic       abort,
  input  wire logic       drive_both,
  input  wire logic       assist,
  input  wire logic       flow_ctrl,
  input  wire logic       pin_in,
  output logic            busy,
  output logic            done,
  output logic            collision,
  output logic            pin_out,
  output logic            pin_oe_n
);
  tx_state_e  state_r;
  logic [7:0] shift_r;
  logic [2:0] bits_r;
  logic [9:0] tick_r;
  logic       prev_r;
  logic       out_r;
  logic       oe_n_r;
  logic       done_r;
  logic       coll_r;

  // Bit timing and the level currently sent
  wire bit_end  = tick_r == bit_period - 10'h001;
  wire centre   = tick_r == (bit_period >> 1);
  wire pre_mid  = tick_r < (bit_period >> 1);
  wire cur_bit  = (state_r == TX_DATA) ? shift_r[0] :
                  (state_r == TX_STOP);
  wire own_bits = state_r == TX_START || state_r == TX_DATA;
  wire in_frame = own_bits || (state_r == TX_STOP && pre_mid);
  wire drv_low  = own_bits && !cur_bit;
  wire rise     = cur_bit && !prev_r && tick_r == 10'h000;
  wire drv_high = !in_frame || !cur_bit ? 1'b0 :
                  drive_both && assist ? rise :
                  drive_both ? 1'b1 :
                  assist ? (!pin_in && pre_mid) : 1'b0;
  // Own high bit read back low means the host talks over us
  wire coll_now = centre && cur_bit && !pin_in &&
                  (state_r == TX_DATA || state_r == TX_STOP);

  assign busy      = state_r != TX_IDLE;
  assign done      = done_r;
  assign collision = coll_r;
  assign pin_out   = out_r;
  assign pin_oe_n  = oe_n_r;

  // Pin drive is registered, so every drive lasts whole clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r  <= 1'b0;
      oe_n_r <= 1'b1;
      coll_r <= 1'b0;
      prev_r <= 1'b1;
    end else begin
      out_r  <= drv_high;
      oe_n_r <= !(drv_low || drv_high);
      coll_r <= coll_now && !abort;
      prev_r <= (state_r == TX_HOST_START) ? 1'b0 :
                (state_r == TX_IDLE) ? 1'b1 : cur_bit;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= TX_IDLE;
      shift_r <= 8'h00;
      bits_r  <= 3'h0;
      tick_r  <= 10'h000;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      tick_r <= bit_end ? 10'h000 : tick_r + 10'h001;
      if (abort) begin
        state_r <= TX_IDLE;
      end else begin
        case (state_r)
          TX_IDLE: begin
            tick_r <= 10'h000;
            if (start) begin
              shift_r <= data;
              bits_r  <= 3'h0;
              state_r <= flow_ctrl ? TX_WAIT : TX_START;
            end
          end
          TX_WAIT: begin
            tick_r <= 10'h000;
            if (!pin_in) state_r <= TX_HOST_START;
          end
          TX_HOST_START, TX_START: begin
            if (bit_end) state_r <= TX_DATA;
          end
          TX_DATA: begin
            if (bit_end) begin
              shift_r <= shift_r >> 1;
              bits_r  <= bits_r + 3'h1;
              if (bits_r == `DATA_BITS) state_r <= TX_STOP;
            end
          end
          TX_STOP: begin
            if (bit_end) begin
              state_r <= TX_IDLE;
              done_r  <= 1'b1;
            end
          end
          default: state_r <= TX_IDLE;
        endcase
      end
    end
  end
endmodule : serial_tx
`default_nettype wire

// File: core/debug_link_and_breakpoint_unit.sv
// Debug serial link, autobaud, breakpoints and debug counter
`timescale 1ns/1ps
`default_nettype none
`include "dbg_params.svh"
module debug_link_and_breakpoint_unit
  import dbg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  input  wire cpu_s        cpu,
  output logic             cpu_idle,
  output logic             cpu_brk_loop,
  output logic             cpu_brk_nop,
  input  wire logic        clk_switch,
  input  wire logic        cmd_byte_dec,
  output logic             cmd_full_en,
  output logic             cmd_abort,
  output logic             rx_valid,
  output logic [7:0]       rx_data
);
  ctl_s        ctl_r;
  ctl_s        ctl_nxt;
  logic [7:0]  sticky_r;
  logic [15:0] rdata_r;
  logic        baud_ok_r;
  logic        meas_r;
  logic [12:0] ab_cnt_r;
  logic [9:0]  period_r;
  logic [15:0] low_cnt_r;
  logic        hold_r;
  logic [12:0] brk_cnt_r;
  rx_state_e   rx_state_r;
  logic [9:0]  rx_tick_r;
  logic [2:0]  rx_bits_r;
  logic [7:0]  rx_shift_r;
  logic        rx_valid_r;
  logic [7:0]  rx_data_r;
  logic        rx_full_r;
  logic        pin_prev_r;
  logic        looping_r;
  logic [15:0] cnt_r;
  logic        cnt_run_r;
  logic        dbg_prev_r;
  logic        tx_busy;
  logic        tx_done;
  logic        tx_coll;
  logic        tx_pin_out;
  logic        tx_pin_oe_n;

  // Register port decode
  wire wr_ctrl = reg_wr && reg_addr == `ADDR_CTRL;
  wire wr_stat = reg_wr && reg_addr == `ADDR_STAT;
  wire wr_cnt  = reg_wr && reg_addr == `ADDR_CNT;
  wire wr_tx   = reg_wr && reg_addr == `ADDR_TXDATA;
  wire rd_rx   = reg_rd && reg_addr == `ADDR_RXDATA;

  // Line state shared by receiver and break logic
  wire brk_active = brk_cnt_r != 13'h0000;
  wire link_up    = baud_ok_r && !hold_r && !brk_active;
  wire fall       = pin_prev_r && !pin_in;
  wire [15:0] brk_len = 16'(period_r) * 16'(`BREAK_BITS);

  // Host break: the line held low for ten bit times
  wire brk_det = baud_ok_r && !brk_active && !hold_r &&
                 low_cnt_r == brk_len;

  // Receiver timing and framing check
  wire rx_end    = rx_tick_r == period_r - 10'h001;
  wire rx_centre = rx_tick_r == (period_r >> 1);
  wire fr_err    = rx_state_r == RX_STOP && rx_end && !pin_in;

  // Any line error aborts and answers with a break
  wire line_err  = brk_det || fr_err || tx_coll;
  wire clk_sw_go = clk_switch && baud_ok_r;
  wire ab_reset  = line_err || clk_sw_go || hold_r;
  wire send_brk  = line_err || clk_sw_go;

  // Breakpoint decisions
  wire dbg      = ctl_r.debug_mode_flag;
  wire brk_take = cpu.brk_decode && ctl_r.brk_enable && !dbg;
  wire loop_now = brk_take && ctl_r.break_loop_enable;
  wire brk_halt = brk_take && !ctl_r.break_loop_enable;
  wire running  = cnt_run_r && !dbg;
  wire cnt_zero = cnt_r == `CNT_ZERO;
  wire down_brk = running && ctl_r.cnt_mode == CNT_DOWN &&
                  cnt_r == `CNT_ONE;
  wire match_brk = !dbg && ctl_r.cnt_mode == CNT_MATCH &&
                   cpu.fetch_valid && cpu.pc == cnt_r;
  wire enter_dbg = brk_halt || down_brk || match_brk;
  wire exit_dbg  = dbg_prev_r && !dbg;

  // Status word as software sees it
  wire [7:0] status = {sticky_r[7:5], rx_full_r, tx_busy, baud_ok_r,
                       looping_r, dbg};

  // Read data, one cycle after the strobe; unmapped reads give zero
  wire [15:0] rd_mux =
    reg_addr == `ADDR_CTRL   ? {8'h00, ctl_r} :
    reg_addr == `ADDR_STAT   ? {8'h00, status} :
    reg_addr == `ADDR_CNT    ? ~cnt_r :
    reg_addr == `ADDR_RXDATA ? {8'h00, rx_data_r} :
    reg_addr == `ADDR_BAUD   ? {6'h00, period_r} : 16'h0000;

  // Outputs toward processor, command engine and pin
  assign reg_rdata    = rdata_r;
  assign cpu_idle     = dbg;
  assign cpu_brk_loop = loop_now;
  assign cpu_brk_nop  = cpu.brk_decode && !ctl_r.brk_enable;
  assign cmd_full_en  = dbg && !looping_r && !hold_r;
  assign cmd_abort    = line_err;
  assign rx_valid     = rx_valid_r;
  assign rx_data      = rx_data_r;
  // Our break overrides the transmitter; both open drain low
  assign pin_out      = brk_active ? 1'b0 : tx_pin_out;
  assign pin_oe_n     = brk_active ? 1'b0 : tx_pin_oe_n;

  // Control update; hardware entry wins over a software clear
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctrl) ctl_nxt = ctl_s'(reg_wdata[7:0]);
    if (enter_dbg) ctl_nxt.debug_mode_flag = 1'b1;
  end

  // Control register is untouched by host breaks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= ctl_s'(8'h00);
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata_r <= 16'h0000;
    else     rdata_r <= reg_rd ? rd_mux : 16'h0000;
  end

  // Sticky error flags: write one to clear, a new error wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sticky_r <= 8'h00;
    end else begin
      if (wr_stat) sticky_r <= sticky_r & ~reg_wdata[7:0];
      if (fr_err)  sticky_r[`ST_FRAME] <= 1'b1;
      if (tx_coll) sticky_r[`ST_COLL]  <= 1'b1;
      if (brk_det) sticky_r[`ST_BREAK] <= 1'b1;
    end
  end

  // Autobaud: time the eight low bits of the first character
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_ok_r <= 1'b0;
      meas_r    <= 1'b0;
      ab_cnt_r  <= 13'h0000;
      period_r  <= 10'h000;
    end else if (ab_reset) begin
      baud_ok_r <= 1'b0;
      meas_r    <= 1'b0;
      ab_cnt_r  <= 13'h0000;
    end else if (!baud_ok_r && !brk_active) begin
      if (!meas_r) begin
        meas_r   <= fall;
        ab_cnt_r <= 13'h0001;
      end else if (pin_in) begin
        meas_r <= 1'b0;
        // An overflowed or too short count leaves autobaud reset
        if (ab_cnt_r < `BAUD_OVF && ab_cnt_r[12:3] != 10'h000) begin
          baud_ok_r <= 1'b1;
          period_r  <= ab_cnt_r[12:3];
        end
      end else if (ab_cnt_r != `BAUD_OVF) begin
        ab_cnt_r <= ab_cnt_r + 13'h0001;
      end
    end
  end

  // Low time counter and hold while the host break lasts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_r  <= 16'h0000;
      hold_r     <= 1'b0;
      pin_prev_r <= 1'b1;
    end else begin
      pin_prev_r <= pin_in;
      if (pin_in || brk_active) low_cnt_r <= 16'h0000;
      else if (low_cnt_r != `CNT_MAX) low_cnt_r <= low_cnt_r + 16'h0001;
      // Released only once the line is high again
      if (brk_det) hold_r <= 1'b1;
      else if (pin_in && !brk_active) hold_r <= 1'b0;
    end
  end

  // Break generator, reloaded by any new cause
  always_ff @(posedge clk or posedge rst) begin
    if (rst) brk_cnt_r <= 13'h0000;
    else if (send_brk) brk_cnt_r <= `BREAK_CYCLES;
    else if (brk_active) brk_cnt_r <= brk_cnt_r - 13'h0001;
  end

  // Receiver; ignores the line while we transmit (half duplex)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_r <= RX_IDLE;
      rx_tick_r  <= 10'h000;
      rx_bits_r  <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_valid_r <= 1'b0;
      rx_data_r  <= 8'h00;
    end else begin
      rx_valid_r <= 1'b0;
      rx_tick_r  <= rx_tick_r + 10'h001;
      if (!link_up || tx_busy || line_err) begin
        rx_state_r <= RX_IDLE;
      end else begin
        case (rx_state_r)
          RX_IDLE: begin
            rx_tick_r <= 10'h000;
            if (fall) rx_state_r <= RX_START;
          end
          RX_START: begin
            // Resample at the centre to reject glitches
            if (rx_centre) begin
              rx_tick_r  <= 10'h000;
              rx_bits_r  <= 3'h0;
              rx_state_r <= pin_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_end) begin
              rx_tick_r  <= 10'h000;
              rx_shift_r <= {pin_in, rx_shift_r[7:1]};
              rx_bits_r  <= rx_bits_r + 3'h1;
              if (rx_bits_r == `DATA_BITS) rx_state_r <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_end) begin
              rx_state_r <= RX_IDLE;
              rx_valid_r <= pin_in;
              rx_data_r  <= rx_shift_r;
            end
          end
          default: rx_state_r <= RX_IDLE;
        endcase
      end
    end
  end

  // Received byte flag; a new byte wins over the clearing read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rx_full_r <= 1'b0;
    else if (rx_valid_r) rx_full_r <= 1'b1;
    else if (rd_rx) rx_full_r <= 1'b0;
  end

  // Loop flag follows the processor at the break instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      looping_r  <= 1'b0;
      dbg_prev_r <= 1'b0;
    end else begin
      dbg_prev_r <= dbg;
      if (loop_now) looping_r <= 1'b1;
      else if (enter_dbg || dbg) looping_r <= 1'b0;
    end
  end

  // Debug counter; stored value is the inverse of what reads show
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= `CNT_ZERO;
      cnt_run_r <= 1'b0;
    end else if (wr_cnt) begin
      cnt_r <= reg_wdata;
    end else if (exit_dbg) begin
      // Cycle mode restarts so that a read shows zero
      if (ctl_r.cnt_mode == CNT_CYCLE) cnt_r <= `CNT_MAX;
      cnt_run_r <= ctl_r.cnt_mode == CNT_CYCLE ||
                   ctl_r.cnt_mode == CNT_DOWN;
    end else if (dbg) begin
      cnt_run_r <= 1'b0;
      // Commands use the counter as a byte count
      if (cmd_byte_dec) cnt_r <= cnt_r - 16'h0001;
    end else if (running) begin
      // Stored zero reads back as the maximum count
      if (cnt_zero) cnt_run_r <= 1'b0;
      else cnt_r <= cnt_r - 16'h0001;
      if (down_brk) cnt_run_r <= 1'b0;
    end
  end

  // Transmitter, started by a write to the data register
  serial_tx u_tx (
    .clk        (clk),
    .rst        (rst),
    .start      (wr_tx && link_up),
    .data       (reg_wdata[7:0]),
    .bit_period (period_r),
    .abort      (line_err || !link_up),
    .drive_both (ctl_r.drive_both),
    .assist     (ctl_r.drive_high_assist),
    .flow_ctrl  (ctl_r.flow_ctrl),
    .pin_in     (pin_in),
    .busy       (tx_busy),
    .done       (tx_done),
    .collision  (tx_coll),
    .pin_out    (tx_pin_out),
    .pin_oe_n   (tx_pin_oe_n)
  );

  // Completion pulse is folded into the busy status bit
  wire unused_done = tx_done;
endmodule : debug_link_and_breakpoint_unit
`default_nettype wire

// File: tb/dbg_assertions.sv
// Port checker for the debug link and breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module dbg_assertions
  import dbg_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        pin_out,
  input wire logic        pin_oe_n,
  input wire cpu_s        cpu,
  input wire logic        cpu_idle,
  input wire logic        cpu_brk_loop,
  input wire logic        cpu_brk_nop,
  input wire logic        cmd_full_en,
  input wire logic        cmd_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        drv_low;
  logic [12:0] low_cnt_r;
  assign drv_low = !pin_oe_n && !pin_out;
  // Length of the present driven-low run, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) low_cnt_r <= 13'h0000;
    else if (!drv_low) low_cnt_r <= 13'h0000;
    else if (low_cnt_r != 13'h1fff) low_cnt_r <= low_cnt_r + 13'h0001;
  end
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  nop_cause_a: assert property (
    cpu_brk_nop |-> cpu.brk_decode && !cpu_brk_loop)
    else $error("break nop without break decode");
  brk_halt_a: assert property (
    cpu.brk_decode && !cpu_brk_nop && !cpu_brk_loop && !reg_wr |=> cpu_idle)
    else $error("enabled break did not idle the processor");
  loop_run_a: assert property (
    cpu_brk_loop && !reg_wr |=> !cpu_idle)
    else $error("looping break entered debug mode");
  full_cmd_a: assert property (
    cpu_brk_loop || !cpu_idle |-> !cmd_full_en)
    else $error("full command set outside debug mode");
  abort_pulse_a: assert property (
    cmd_abort |=> !cmd_abort)
    else $error("abort longer than one cycle");
  abort_brk_a: assert property (
    cmd_abort |-> ##[1:2] drv_low)
    else $error("no break driven after line error");
  brk_len_a: assert property (
    $fell(drv_low) |-> low_cnt_r < 13'h0401 || low_cnt_r == 13'h1000)
    else $error("break length not 4096 clocks");
  keep_dbg_a: assert property (
    cmd_abort && cpu_idle && !reg_wr |=> cpu_idle)
    else $error("line error left debug mode");
endmodule : dbg_assertions

bind debug_link_and_breakpoint_unit dbg_assertions chk (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .cpu(cpu), .cpu_idle(cpu_idle), .cpu_brk_loop(cpu_brk_loop),
  .cpu_brk_nop(cpu_brk_nop), .cmd_full_en(cmd_full_en),
  .cmd_abort(cmd_abort));
`default_nettype wire

// File: tb/host_model.sv
// Host debugger on the open-drain debug pin
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk,
  output logic      pull_low
);
  int unsigned per = 16;
  // Released line rises through the pull-up
  initial pull_low = 1'b0;
  // Start, eight data LSB first, stop; stp low forces a framing fault
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull_low <= !f[i];
      repeat (per) @(posedge clk);
    end
    // A high stop bit has released the line already
    if (!stp) pull_low <= 1'b0;
  endtask : send
  // Line held low for n bit times
  task automatic break_instruction(input int n);
    pull_low <= 1'b1;
    repeat (n * per) @(posedge clk);
    pull_low <= 1'b0;
  endtask : break_instruction
endmodule : host_model
`default_nettype wire

// File: tb/test_debug_link_and_breakpoint_unit.sv
// Bench for the debug link and breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module test_debug_link_and_breakpoint_unit;
  import dbg_pkg::*;
  localparam int P = 16;
  logic clk, rst, reg_wr, reg_rd, clk_switch, cmd_byte_dec;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic pin, pin_out, pin_oe_n, pull_low, cpu_idle, cpu_brk_loop;
  logic cpu_brk_nop, cmd_full_en, cmd_abort, rx_valid;
  logic [7:0] rx_data, r, mb;
  cpu_s cpu;
  logic rd_d, exp_oe, mon_on, rx_ign;
  logic [31:0] e;
  logic [31:0] rd_q[$];
  logic [7:0] rx_q[$], tx_q[$];
  int failures, n_compared, n_abort, a0, n, seed;
  // Wired-AND of both open-drain parties over a pull-up
  assign pin = !((!pin_oe_n && !pin_out) || pull_low);
  debug_link_and_breakpoint_unit DUT (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cpu(cpu),
    .cpu_idle(cpu_idle), .cpu_brk_loop(cpu_brk_loop),
    .cpu_brk_nop(cpu_brk_nop), .clk_switch(clk_switch),
    .cmd_byte_dec(cmd_byte_dec), .cmd_full_en(cmd_full_en),
    .cmd_abort(cmd_abort), .rx_valid(rx_valid), .rx_data(rx_data));
  host_model host (.clk(clk), .pull_low(pull_low));
  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] s, x);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Spare edge, so a following strobe is never set twice in one step
    @(posedge clk);
  endtask : wr
  // Read noting the expected word and the bits that matter
  task automatic rd(input logic [2:0] a, input logic [15:0] x, m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back({m, x});
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Wait out any break, then send the baud character
  task automatic rebaud();
    rx_ign = 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6000 && pin !== 1'b1; i++) @(posedge clk);
    repeat (2 * P) @(posedge clk);
    host.send(8'h80, 1'b1);
    repeat (2 * P) @(posedge clk);
    rx_ign = 1'b0;
  endtask : rebaud
  // Read answers stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      e = rd_q.pop_front();
      check("reg_rdata", reg_rdata & e[31:16], e[15:0]);
    end
    rd_d <= reg_rd;
  end
  // Received bytes against the host's notes
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && !rx_ign)
      check("rx_data", {8'h00, rx_data}, {8'h00, rx_q.pop_front()});
    if (cmd_abort === 1'b1) n_abort++;
  end
  // Recovers device characters at bit centres; drive state on 1 bits
  initial forever begin
    @(negedge pin);
    if (mon_on) begin
      repeat (P / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (P) @(posedge clk);
        mb[i] = pin;
        if (pin) check("pin_oe_n", 16'(pin_oe_n), 16'(exp_oe));
      end
      repeat (P) @(posedge clk);
      check("stop", 16'(pin), 16'h0001);
      check("tx_char", {8'h00, mb}, {8'h00, tx_q.pop_front()});
    end
  end
  // Cuts a hang short; the sequence needs about 25k cycles
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    cpu = '0;
    clk_switch = 1'b0;
    cmd_byte_dec = 1'b0;
    mon_on = 1'b0;
    rx_ign = 1'b0;
    seed = 13;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(3'h0, 16'h0000, 16'hffff);
    rd(3'h2, 16'hffff, 16'hffff);
    wr(3'h6, 16'hffff);
    rd(3'h6, 16'h0000, 16'hffff);
    wr(3'h0, 16'h0001);
    // Connect: an overlong break overflows autobaud, then baud is set
    host.break_instruction(300);
    rebaud();
    a0 = n_abort;
    host.break_instruction(12);
    rebaud();
    check("abort", 16'(n_abort != a0), 16'h0001);
    check("cpu_idle", 16'(cpu_idle), 16'h0001);
    rd(3'h0, 16'h0001, 16'h00ff);
    rd(3'h5, 16'(P), 16'hffff);
    rd(3'h1, 16'h0004, 16'h0004);
    // Back-to-back host characters
    for (int i = 0; i < 3; i++) begin
      r = 8'($random(seed));
      rx_q.push_back(r);
      host.send(r, 1'b1);
    end
    repeat (P) @(posedge clk);
    check("rx_left", 16'(rx_q.size()), 16'h0000);
    // Drive modes 0..3, then flow control released by the host
    mon_on = 1'b1;
    rx_ign = 1'b1;
    for (int m = 0; m < 5; m++) begin
      wr(3'h0, 16'h0001 | (16'(m) << 3));
      exp_oe = m != 1; // Only drive-both still holds a high bit
      r = 8'($random(seed));
      tx_q.push_back(r);
      wr(3'h3, {8'h00, r});
      if (m == 4) begin
        repeat (3 * P) @(posedge clk);
        check("pin_wait", 16'(pin), 16'h0001);
        host.send(8'hff, 1'b1);
      end
      repeat (12 * P) @(posedge clk);
    end
    mon_on = 1'b0;
    check("tx_left", 16'(tx_q.size()), 16'h0000);
    wr(3'h0, 16'h0001);
    // Framing fault, then collision on a released data bit
    a0 = n_abort;
    host.send(8'h5a, 1'b0);
    rd(3'h1, 16'h0020, 16'h0020);
    wr(3'h1, 16'h00e0);
    rebaud();
    check("abort", 16'(n_abort != a0), 16'h0001);
    rd(3'h1, 16'h0004, 16'h0024);
    a0 = n_abort;
    rx_ign = 1'b1;
    wr(3'h3, 16'h00ff);
    repeat (P + 4) @(posedge clk);
    host.break_instruction(1);
    rd(3'h1, 16'h0040, 16'h0040);
    rebaud();
    check("abort", 16'(n_abort != a0), 16'h0001);
    clk_switch <= 1'b1;
    @(posedge clk);
    clk_switch <= 1'b0;
    repeat (4200) @(posedge clk);
    rd(3'h1, 16'h0000, 16'h0004);
    // Break instruction: nop, halt, loop, loop released
    wr(3'h0, 16'h0000);
    cpu.brk_decode <= 1'b1;
    @(negedge clk);
    check("brk_nop", 16'(cpu_brk_nop), 16'h0001);
    @(posedge clk);
    cpu.brk_decode <= 1'b0;
    @(negedge clk);
    check("cpu_idle", 16'(cpu_idle), 16'h0000);
    wr(3'h0, 16'h0002);
    cpu.brk_decode <= 1'b1;
    @(posedge clk);
    cpu.brk_decode <= 1'b0;
    @(negedge clk);
    check("cpu_idle", 16'(cpu_idle), 16'h0001);
    check("full_en", 16'(cmd_full_en), 16'h0001);
    @(posedge clk);
    wr(3'h0, 16'h0006);
    cpu.brk_decode <= 1'b1;
    @(negedge clk);
    check("brk_loop", 16'(cpu_brk_loop), 16'h0001);
    check("full_en", 16'(cmd_full_en), 16'h0000);
    @(posedge clk);
    rd(3'h1, 16'h0002, 16'h0003);
    wr(3'h0, 16'h0002);
    repeat (2) @(posedge clk);
    cpu.brk_decode <= 1'b0;
    @(negedge clk);
    check("cpu_idle", 16'(cpu_idle), 16'h0001);
    // Counter: byte count, cycle count, countdown, address match
    @(posedge clk);
    wr(3'h2, 16'h0005);
    cmd_byte_dec <= 1'b1;
    repeat (2) @(posedge clk);
    cmd_byte_dec <= 1'b0;
    rd(3'h2, 16'hfffc, 16'hffff);
    wr(3'h0, 16'h0002);
    repeat (40) @(posedge clk);
    wr(3'h0, 16'h0003);
    rd(3'h2, 16'h0028, 16'hfff8);
    repeat (10) @(posedge clk);
    rd(3'h2, 16'h0028, 16'hfff8);
    wr(3'h2, 16'h0014);
    wr(3'h0, 16'h0042);
    for (n = 0; n < 40 && cpu_idle !== 1'b1; n++) @(posedge clk);
    check("down_len", 16'(n) & 16'hfff8, 16'h0010);
    rd(3'h2, 16'hffff, 16'hffff);
    wr(3'h2, 16'h1234);
    wr(3'h0, 16'h0082);
    cpu.fetch_valid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      cpu.pc <= 16'($random(seed)) | 16'h0001;
      @(posedge clk);
    end
    rd(3'h2, 16'hedcb, 16'hffff);
    check("cpu_idle", 16'(cpu_idle), 16'h0000);
    cpu.pc <= 16'h1234;
    @(posedge clk);
    cpu.fetch_valid <= 1'b0;
    @(negedge clk);
    check("cpu_idle", 16'(cpu_idle), 16'h0001);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : test_debug_link_and_breakpoint_unit
`default_nettype wire
